// File: hw/lsc_top.sv
/*
 Serial low-side output controller: eight switches driven from an 8-bit
 serially loaded control register, with a force-on for switch 1, brown-out
 blanking and a power-on reset output.
 Assumes: digital levels for supply-good and brown-out comparators; the
 serial clock is a separate clock domain stopping between frames.
*/
// Functional notes
// - Every transfer is one 8-bit frame clocked by the master's serial clock.
// - One control register, one bit per low-side switch, sets its on/off.
// - Control register resets to zero; all switches off until written, except switch 1 while force input high.
// - Force input low: switch 1 follows its register bit.
// - Force input high: switch 1 on, its register bit ignored.
// - Brown-out: flag driven low and all eight switches disabled.
// - After brown-out, switches return to held register state; register kept.
// - Reset output low until supply good and delay timer expired.
// - Reset asserted: switches off and control register cleared.
// - Link accepted only with select low; select rise after 8 bits loads.
// - Bit 1 means on; MSB is switch 8, LSB is switch 1.
`timescale 1ns/10ps
module lsc_top #(
   parameter int unsigned RST_DELAY_CYCLES = lsc_pkg::RST_DELAY_CYC
) (
   input  wire logic                               core_clk,
   input  wire logic                               arst_n,
   input  wire logic                               sclk,
   input  wire logic                               chip_select_n,
   input  wire logic                               serial_data_in,
   input  wire logic                               switch1_force_on,
   input  wire logic                               brownout_sense_in,
   input  wire logic                               supply_good,
   input  wire logic                               reset_pin_in,
   output logic                                    reset_pin_out,
   output logic                                    reset_pin_oe_n,
   output logic                                    brownout_flag_n,
   output logic      [lsc_pkg::SWITCH_COUNT-1:0]   low_side_switch
);
   import lsc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [SWITCH_COUNT-1:0] ctrl;
      logic [SWITCH_COUNT-1:0] sw;
      logic                    flag_n;
      logic                    rst_low;
      logic                    cs_d;
      lsc_rst_state_e          rst_st;
      logic [31:0]             dly_cnt;
   } lsc_top_s;

   lsc_top_s st_ff;
   lsc_top_s nxt_st;

   logic [FRAME_BITS-1:0] shift_data;
   logic [3:0]            bit_count;
   logic                  cs_s;
   logic                  force_s;
   logic                  bo_s;
   logic                  good_s;
   logic                  rstin_s;
   logic [FRAME_BITS-1:0] data_s;
   logic [3:0]            cnt_s;

   // ----------------------------------------------------------------
   // Link side
   // ----------------------------------------------------------------
   lsc_shift u_shift (
      .sclk           (sclk),
      .arst_n         (arst_n),
      .chip_select_n  (chip_select_n),
      .serial_data_in (serial_data_in),
      .shift_data     (shift_data),
      .bit_count      (bit_count)
   );

   // Frame words are static once select rises, so a multibit two-flop copy
   // is safe: they are only used a synchroniser delay after the rise.
   lsc_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_cs (
      .clk    (core_clk),
      .arst_n (arst_n),
      .d      (chip_select_n),
      .q      (cs_s)
   );

   lsc_sync #(.WIDTH(FRAME_BITS + 4), .RST_VAL('0)) u_sync_frame (
      .clk    (core_clk),
      .arst_n (arst_n),
      .d      ({shift_data, bit_count}),
      .q      ({data_s, cnt_s})
   );

   // Brown-out sense resets to its healthy level so that leaving reset does
   // not flash the brown-out flag low for two cycles.
   lsc_sync #(.WIDTH(4), .RST_VAL(4'h4)) u_sync_pins (
      .clk    (core_clk),
      .arst_n (arst_n),
      .d      ({switch1_force_on, brownout_sense_in, supply_good, reset_pin_in}),
      .q      ({force_s, bo_s, good_s, rstin_s})
   );

   // ----------------------------------------------------------------
   // Core logic
   // ----------------------------------------------------------------
   logic                    load;
   logic [SWITCH_COUNT-1:0] eff;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.cs_d = cs_s;
      // Select rise after exactly eight bits loads the frame; short or
      // long frames are dropped so a glitching select cannot corrupt state.
      load = cs_s && !st_ff.cs_d && (cnt_s == BIT_CNT_FULL);
      if (load) begin
         nxt_st.ctrl = data_s;
      end

      // Power-on reset sequencing
      unique case (st_ff.rst_st)
         LSC_RST_HOLD: begin
            nxt_st.rst_low = 1'b1;
            nxt_st.dly_cnt = '0;
            if (good_s) begin
               nxt_st.rst_st = LSC_RST_COUNT;
            end
         end
         LSC_RST_COUNT: begin
            nxt_st.rst_low = 1'b1;
            if (!good_s) begin
               nxt_st.rst_st = LSC_RST_HOLD;
            end else if (st_ff.dly_cnt >= RST_DELAY_CYCLES - 1) begin
               nxt_st.rst_st  = LSC_RST_DONE;
               nxt_st.rst_low = 1'b0;
            end else begin
               nxt_st.dly_cnt = st_ff.dly_cnt + 32'h1;
            end
         end
         LSC_RST_DONE: begin
            nxt_st.rst_low = 1'b0;
            if (!good_s) begin
               nxt_st.rst_st  = LSC_RST_HOLD;
               nxt_st.rst_low = 1'b1;
            end
         end
         default: begin
            nxt_st.rst_st  = LSC_RST_HOLD;
            nxt_st.rst_low = 1'b1;
         end
      endcase

      // Reset seen on the shared pin (ours or someone else's) clears all
      if (st_ff.rst_low || !rstin_s) begin
         nxt_st.ctrl = CTRL_RESET_VAL;
      end

      eff = nxt_st.ctrl;
      if (force_s) begin
         eff[SW1_BIT] = 1'b1;
      end
      nxt_st.flag_n = bo_s;
      if (!bo_s || st_ff.rst_low || !rstin_s) begin
         nxt_st.sw = '0;
      end else begin
         nxt_st.sw = eff;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff.ctrl    <= CTRL_RESET_VAL;
         st_ff.sw      <= '0;
         st_ff.flag_n  <= 1'b1;
         st_ff.rst_low <= 1'b1;
         st_ff.cs_d    <= 1'b1;
         st_ff.rst_st  <= LSC_RST_HOLD;
         st_ff.dly_cnt <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open drain: pin only ever driven low, oe_n low while pulling
   assign reset_pin_out   = 1'b0;
   assign reset_pin_oe_n  = ~st_ff.rst_low;
   assign brownout_flag_n = st_ff.flag_n;
   assign low_side_switch = st_ff.sw;

endmodule : lsc_top

// File: shared/lsc_pkg.sv
/*
 Constants and types for the serial low-side output controller.
 Assumes: shared by every design file of the block; no timescale here.
*/
package lsc_pkg;

   // ----------------------------------------------------------------
   // Frame and register layout
   // ----------------------------------------------------------------
   localparam int unsigned          FRAME_BITS     = 8;
   localparam int unsigned          SWITCH_COUNT   = 8;
   localparam int unsigned          SW1_BIT        = 0;
   localparam logic [7:0]           CTRL_RESET_VAL = 8'h00;
   localparam logic [3:0]           BIT_CNT_ZERO   = 4'h0;
   localparam logic [3:0]           BIT_CNT_FULL   = 4'h8;
   localparam logic [3:0]           BIT_CNT_SAT    = 4'hf;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned          CORE_CLK_MHZ   = 50;
   localparam int unsigned          RST_DELAY_US   = 6000;
   localparam int unsigned          RST_DELAY_CYC  = RST_DELAY_US * CORE_CLK_MHZ;
   localparam int unsigned          SYNC_STAGES    = 2;

   typedef enum logic [1:0] {
      LSC_RST_HOLD,
      LSC_RST_COUNT,
      LSC_RST_DONE
   } lsc_rst_state_e;

endpackage : lsc_pkg

// File: hw/lsc_sync.sv
/*
 Two-flop level synchroniser into the destination clock.
 Assumes: input is a level, stable long enough to be seen; reset is async low.
*/
`timescale 1ns/10ps
module lsc_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   import lsc_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } lsc_sync_s;

   lsc_sync_s st_ff;
   lsc_sync_s nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = d;
      nxt_st.sync = st_ff.meta;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= {RST_VAL, RST_VAL};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.sync;

endmodule : lsc_sync

// File: hw/lsc_shift.sv
/*
 Serial shifter on the link clock.
 Assumes: serial clock idles low with chip select high, sampling on its
 rising edge, MSB first; clock stops outside frames.
*/
`timescale 1ns/10ps
module lsc_shift (
   input  wire logic                               sclk,
   input  wire logic                               arst_n,
   input  wire logic                               chip_select_n,
   input  wire logic                               serial_data_in,
   output logic      [lsc_pkg::FRAME_BITS-1:0]     shift_data,
   output logic      [3:0]                         bit_count
);
   import lsc_pkg::*;

   typedef struct packed {
      logic [FRAME_BITS-1:0] data;
      logic [3:0]            cnt;
   } lsc_shift_s;

   lsc_shift_s st_ff;
   lsc_shift_s nxt_st;
   logic       first_bit_ff;

   // ----------------------------------------------------------------
   // Shift path
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (!chip_select_n) begin
         nxt_st.data = {st_ff.data[FRAME_BITS-2:0], serial_data_in};
         if (first_bit_ff) begin
            nxt_st.cnt = BIT_CNT_ZERO + 4'h1;
         end else if (st_ff.cnt != BIT_CNT_SAT) begin
            // Saturates well above eight so long frames never alias to eight
            nxt_st.cnt = st_ff.cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge sclk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // The count must still stand after select rises, so the core can read it
   // a synchroniser delay later; select high only arms a restart, which the
   // first clock of the next frame carries out.
   always_ff @(posedge sclk or posedge chip_select_n or negedge arst_n) begin
      if (!arst_n) begin
         first_bit_ff <= 1'b1;
      end else if (chip_select_n) begin
         first_bit_ff <= 1'b1;
      end else begin
         first_bit_ff <= 1'b0;
      end
   end

   assign bit_count  = st_ff.cnt;
   assign shift_data = st_ff.data;

endmodule : lsc_shift

// File: tb/lsc_properties.sv
/* Port checker for lsc_top.
 Assumes: bound to lsc_top; one core clock domain. */
`timescale 1ns/10ps
module lsc_properties #(
   parameter int unsigned RST_DELAY_CYCLES = 20
) (
   input wire logic       core_clk,
   input wire logic       arst_n,
   input wire logic       chip_select_n,
   input wire logic       switch1_force_on,
   input wire logic       brownout_sense_in,
   input wire logic       supply_good,
   input wire logic       reset_pin_in,
   input wire logic       reset_pin_out,
   input wire logic       reset_pin_oe_n,
   input wire logic       brownout_flag_n,
   input wire logic [7:0] low_side_switch
);
   import lsc_pkg::*;
   // ---------------------------------
   // Supply-good run length
   // ---------------------------------
   int unsigned good_cnt_ff;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) good_cnt_ff <= 0;
      else if (!supply_good) good_cnt_ff <= 0;
      else if (good_cnt_ff < 100000) good_cnt_ff <= good_cnt_ff + 1;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   rst_data_low_a: assert property (reset_pin_out == 1'b0)
      else $error("reset pin data not low");
   rst_early_a: assert property ($rose(reset_pin_oe_n) |-> good_cnt_ff >= RST_DELAY_CYCLES)
      else $error("reset released too early");
   rst_late_a: assert property (good_cnt_ff >= RST_DELAY_CYCLES + 8 |-> reset_pin_oe_n)
      else $error("reset not released");
   rst_fall_a: assert property ($fell(supply_good) |-> ##[1:5] !reset_pin_oe_n)
      else $error("reset not reasserted");
   bo_blank_a: assert property ((!brownout_sense_in)[*5] |-> low_side_switch == 8'h00 && !brownout_flag_n)
      else $error("brown-out not blanking");
   bo_flag_a: assert property (brownout_sense_in[*5] |-> brownout_flag_n)
      else $error("brown-out flag low");
   rst_clear_a: assert property ((!reset_pin_in)[*5] |-> low_side_switch == 8'h00)
      else $error("switches on in reset");
   force_on_a: assert property ((switch1_force_on && brownout_sense_in && reset_pin_in)[*5] |-> low_side_switch[0])
      else $error("switch 1 not forced");
   hold_sw_a: assert property ((!chip_select_n && brownout_sense_in && reset_pin_in && !switch1_force_on)[*6] |=> $stable(low_side_switch))
      else $error("switches changed mid-frame");
   cover property ($fell(brownout_flag_n));
   cover property ($rose(reset_pin_oe_n));
   cover property (low_side_switch[0] && switch1_force_on);
endmodule : lsc_properties
bind lsc_top lsc_properties #(.RST_DELAY_CYCLES(RST_DELAY_CYCLES)) i_props (.core_clk, .arst_n,
   .chip_select_n, .switch1_force_on, .brownout_sense_in, .supply_good, .reset_pin_in,
   .reset_pin_out, .reset_pin_oe_n, .brownout_flag_n, .low_side_switch);

// File: tb/lsc_spi_master.sv
/* Serial bus master model.
 Assumes: the bench calls send_frame; clock stops between frames. */
`timescale 1ns/10ps
module lsc_spi_master (
   output logic sclk,
   output logic chip_select_n,
   output logic serial_data_in
);
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // Data moves on the falling edge, giving 24 ns setup and hold
   task automatic send_frame(input logic [15:0] val, input int nbits);
      chip_select_n = 1'b0;
      #40;
      for (int i = nbits - 1; i >= 0; i--) begin
         serial_data_in = val[i];
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      #80 chip_select_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #200;
   endtask : send_frame
endmodule : lsc_spi_master

// File: tb/test_lsc_top.sv
/* Self-checking bench for lsc_top.
 Assumes: lsc_spi_master as master; short reset delay. */
`timescale 1ns/10ps
module test_lsc_top;
   import lsc_pkg::*;
   localparam int unsigned DLY = 20;
   logic       core_clk = 1'b0;
   logic       arst_n, switch1_force_on, brownout_sense_in, supply_good;
   logic       reset_pin_out, reset_pin_oe_n, brownout_flag_n, rst_wire;
   logic       sclk, chip_select_n, serial_data_in;
   logic [7:0] low_side_switch;
   logic [7:0] pat [5] = '{8'ha5, 8'h5a, 8'h80, 8'h01, 8'hff};
   int         err_total = 0;
   int         n_checks = 0;
   // Pull-up on the shared reset wire
   assign rst_wire = reset_pin_oe_n ? 1'b1 : reset_pin_out;
   always #10 core_clk = ~core_clk;
   lsc_top #(.RST_DELAY_CYCLES(DLY)) i_dut (.core_clk, .arst_n, .sclk, .chip_select_n,
      .serial_data_in, .switch1_force_on, .brownout_sense_in, .supply_good,
      .reset_pin_in(rst_wire), .reset_pin_out, .reset_pin_oe_n, .brownout_flag_n,
      .low_side_switch);
   lsc_spi_master i_mst (.sclk, .chip_select_n, .serial_data_in);
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic write(input logic [15:0] v, input int n);
      i_mst.send_frame(v, n);
      cyc(2);
   endtask : write
   task automatic wait_rel;
      int k;
      k = 0;
      while (reset_pin_oe_n !== 1'b1 && k < 200) begin
         cyc(1);
         k++;
      end
      check({7'h00, reset_pin_oe_n}, 8'h01);
   endtask : wait_rel
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : print_verdict
   // Whole run needs about 14 us; fourteen times that is a hang
   initial begin
      #200000;
      err_total++;
      print_verdict();
   end
   initial begin
      arst_n = 1'b0;
      switch1_force_on = 1'b0;
      brownout_sense_in = 1'b1;
      supply_good = 1'b1;
      cyc(12);
      arst_n = 1'b1;
      check(low_side_switch, 8'h00);
      check({7'h00, reset_pin_oe_n}, 8'h00);
      wait_rel();
      $display("test reset done");
      foreach (pat[i]) begin
         write({8'h00, pat[i]}, 8);
         check(low_side_switch, pat[i]);
      end
      write(16'h0000, 7);
      check(low_side_switch, 8'hff);
      write(16'h0100, 9);
      check(low_side_switch, 8'hff);
      $display("test frames done");
      repeat (2) begin
         write(16'h0001, 8);
         check(low_side_switch, 8'h01);
         write(16'h0000, 8);
         check(low_side_switch, 8'h00);
      end
      $display("test pwm done");
      write(16'h0000, 8);
      switch1_force_on = 1'b1;
      cyc(6);
      check(low_side_switch, 8'h01);
      write(16'h00fe, 8);
      check(low_side_switch, 8'hff);
      switch1_force_on = 1'b0;
      cyc(6);
      check(low_side_switch, 8'hfe);
      $display("test force done");
      brownout_sense_in = 1'b0;
      cyc(6);
      check(low_side_switch, 8'h00);
      check({7'h00, brownout_flag_n}, 8'h00);
      brownout_sense_in = 1'b1;
      cyc(6);
      check(low_side_switch, 8'hfe);
      check({7'h00, brownout_flag_n}, 8'h01);
      $display("test brown-out done");
      supply_good = 1'b0;
      cyc(8);
      check({7'h00, reset_pin_oe_n}, 8'h00);
      check(low_side_switch, 8'h00);
      write(16'h00ff, 8);
      supply_good = 1'b1;
      wait_rel();
      cyc(6);
      check(low_side_switch, 8'h00);
      write(16'h0042, 8);
      check(low_side_switch, 8'h42);
      $display("test reset wire done");
      arst_n = 1'b0;
      cyc(2);
      check(low_side_switch, 8'h00);
      arst_n = 1'b1;
      wait_rel();
      check(low_side_switch, 8'h00);
      $display("test async reset done");
      print_verdict();
   end
endmodule : test_lsc_top
